// ### design/cre_pkg.sv
// Purpose: Shared constants and types for the reset-entry unit
// Assumes: 32-bit virtual addresses, 100 MHz core clock
// Notes: Overview of operation follows
package cre_pkg;
   localparam logic [31:0] CRE_RESET_VADDR = 32'hbfc0_0000;
   localparam logic [31:0] CRE_BOOT_EXC_VADDR = 32'hbfc0_0100;
   localparam logic [31:0] CRE_NORM_EXC_VADDR = 32'h8000_0080;
   localparam logic [31:0] CRE_SEG1_BASE = 32'ha000_0000;
   localparam logic [31:0] CRE_SEG_MASK = 32'h1fff_ffff;
   localparam logic [2:0] CRE_SEG_TOP = 3'h5;
   localparam logic [2:0] CRE_SEG_TOP_POS = 3'h7;
   localparam int CRE_BURST_WORDS = 4;
   // Register map, byte addresses
   localparam logic [7:0] CRE_ADDR_STATUS = 8'h00;
   localparam logic [7:0] CRE_ADDR_RETPC = 8'h04;
   localparam logic [7:0] CRE_ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] CRE_ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] CRE_ADDR_IDENT = 8'h10;
   // Status word field positions
   localparam int CRE_SW_IEN = 0;
   localparam int CRE_SW_UMODE = 1;
   localparam int CRE_SW_ISO = 16;
   localparam int CRE_SW_SHUT = 21;
   localparam int CRE_SW_BOOTV = 22;
   localparam logic [31:0] CRE_SW_WMASK = 32'h0041_0003;
   // Event bits
   localparam int CRE_EV_SHUTDOWN = 0;
   localparam int CRE_EV_EXC = 1;
   localparam int CRE_EV_W = 2;
   localparam logic [31:0] CRE_IDENT_DEFAULT = 32'h0000_5a01;

   typedef enum logic [1:0] {CRE_TR_IDLE, CRE_TR_READ, CRE_TR_WRITE} cre_trans_e;
   typedef struct packed {
      logic [31:0] addr;
      logic uncached;
      logic valid;
   } cre_fetch_s;
   typedef struct packed {
      logic user_mode;
      logic int_enable;
      logic boot_vec;
      logic shutdown;
      logic isolate;
   } cre_status_s;
endpackage

// ### design/cre_xlate.sv
// Purpose: Virtual to physical segment mapping for fetch addresses
// Assumes: Kernel segments only; mapped space handled elsewhere
// Notes: Purely combinational
`timescale 1ns/1ps
module cre_xlate
   import cre_pkg::*;
(
   input wire logic [31:0] vaddr_in,
   input wire logic burst_ok_in,
   output logic [31:0] paddr_out,
   output logic uncached_out
);
   always_comb begin
      paddr_out = vaddr_in & CRE_SEG_MASK;
      // Upper kernel segment is never cached; slow ROMs must live there
      uncached_out = (vaddr_in[31:29] == CRE_SEG_TOP) || !burst_ok_in;
   end
endmodule

// ### design/cre_reset_entry.sv
// Purpose: Reset entry, status word and exception vectoring of the core
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes: Cache and translation arrays are external; only their hooks sit here
`timescale 1ns/1ps
module cre_reset_entry
   import cre_pkg::*;
#(
   parameter logic has_xlate = 1'b1,
   parameter logic [31:0] ident_code = CRE_IDENT_DEFAULT // Arbitrary value
)(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // Pipeline side
   input wire logic [31:0] pc_in,
   input wire logic fetch_adv_in,
   input wire logic [31:0] next_pc_in,
   input wire logic exc_req_in,
   input wire logic burst_ok_in,
   input wire logic dup_match_in,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Fetch request, status and interrupt out
   output cre_fetch_s fetch_out,
   output cre_status_s status_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////////////
   logic [31:0] fetch_vaddr_reg;
   logic fetch_valid_reg;
   logic [31:0] retpc_reg;
   logic [31:0] pc_last_reg;
   cre_status_s sw_reg;
   logic [CRE_EV_W-1:0] irq_stat_reg;
   logic [CRE_EV_W-1:0] irq_mask_reg;
   logic rst_seen_reg;
   logic [31:0] paddr;
   logic uncached;
   logic [31:0] hrdata_next;
   logic [7:0] ph_addr_reg;
   logic ph_wr_reg;
   logic ph_rd_reg;
   logic [CRE_EV_W-1:0] ev;

   function automatic logic [31:0] pack_status(input cre_status_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CRE_SW_IEN] = s.int_enable;
      w[CRE_SW_UMODE] = s.user_mode;
      w[CRE_SW_ISO] = s.isolate;
      w[CRE_SW_SHUT] = s.shutdown;
      w[CRE_SW_BOOTV] = s.boot_vec;
      return w;
   endfunction

   function automatic logic is_write(input logic [7:0] a, input logic [7:0] r);
      return ph_wr_reg && (a == r);
   endfunction

   cre_xlate u_xlate (
      .vaddr_in(fetch_vaddr_reg),
      .burst_ok_in(burst_ok_in),
      .paddr_out(paddr),
      .uncached_out(uncached)
   );

   ////////////////////////////////////////////////////////////////////////
   // Fetch address. Under reset the fetch already points at the reset entry,
   // so the request goes out on the first edge after release.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         fetch_vaddr_reg <= CRE_RESET_VADDR;
         fetch_valid_reg <= 1'b0;
      end else begin
         fetch_valid_reg <= 1'b1;
         if (!fetch_valid_reg) begin
            fetch_vaddr_reg <= CRE_RESET_VADDR;
         end else if (exc_req_in) begin
            fetch_vaddr_reg <= sw_reg.boot_vec ? CRE_BOOT_EXC_VADDR
                                               : CRE_NORM_EXC_VADDR;
         end else if (fetch_adv_in) begin
            fetch_vaddr_reg <= next_pc_in;
         end
      end
   end

   always_comb begin
      fetch_out.addr = fetch_vaddr_reg;
      fetch_out.uncached = uncached;
      fetch_out.valid = fetch_valid_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // Return pc. Pipeline pc is tracked every cycle; reset freezes the last
   // one, so warm and cold resets look alike to software.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rst_seen_reg <= 1'b1;
      end else begin
         rst_seen_reg <= 1'b0;
         pc_last_reg <= pc_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in && !rst_seen_reg) begin
         retpc_reg <= pc_last_reg;
      end else if (!sys_rst_in && exc_req_in) begin
         retpc_reg <= pc_in;
      end
   end
   // No warm/cold flag exists anywhere in the register map
   // Loads and refills in flight are simply abandoned by the pipeline
   // Cache arrays take no reset; early cached loads may hit garbage

   ////////////////////////////////////////////////////////////////////////
   // Status word. Isolate bit is not reset: firmware must clear it.
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sw_reg.user_mode <= 1'b0;
         sw_reg.int_enable <= 1'b0;
         sw_reg.boot_vec <= 1'b1;
         sw_reg.shutdown <= !has_xlate;
      end else begin
         if (has_xlate && dup_match_in) begin
            sw_reg.shutdown <= 1'b1;
         end
         if (is_write(ph_addr_reg, CRE_ADDR_STATUS)) begin
            sw_reg.user_mode <= hwdata[CRE_SW_UMODE];
            sw_reg.int_enable <= hwdata[CRE_SW_IEN];
            sw_reg.boot_vec <= hwdata[CRE_SW_BOOTV];
            // Isolate has no reset branch; it holds whatever it held
            sw_reg.isolate <= hwdata[CRE_SW_ISO];
         end
      end
   end

   assign status_out = sw_reg;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over write-one-to-clear
   always_comb begin
      ev = '0;
      ev[CRE_EV_SHUTDOWN] = has_xlate && dup_match_in && !sw_reg.shutdown;
      ev[CRE_EV_EXC] = exc_req_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_stat_reg <= '0;
      end else if (is_write(ph_addr_reg, CRE_ADDR_IRQ_STAT)) begin
         irq_stat_reg <= (irq_stat_reg & ~hwdata[CRE_EV_W-1:0]) | ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | ev;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_mask_reg <= '0;
      end else if (is_write(ph_addr_reg, CRE_ADDR_IRQ_MASK)) begin
         irq_mask_reg <= hwdata[CRE_EV_W-1:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait; unmapped reads return zero, writes dropped
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ph_wr_reg <= 1'b0;
         ph_rd_reg <= 1'b0;
         ph_addr_reg <= 8'h00;
      end else if (hready) begin
         ph_wr_reg <= hsel && htrans[1] && hwrite;
         ph_rd_reg <= hsel && htrans[1] && !hwrite;
         ph_addr_reg <= haddr[7:0];
      end
   end

   always_comb begin
      unique case (haddr[7:0])
         CRE_ADDR_STATUS: hrdata_next = pack_status(sw_reg);
         CRE_ADDR_RETPC: hrdata_next = retpc_reg;
         CRE_ADDR_IRQ_STAT: hrdata_next = {{(32-CRE_EV_W){1'b0}}, irq_stat_reg};
         CRE_ADDR_IRQ_MASK: hrdata_next = {{(32-CRE_EV_W){1'b0}}, irq_mask_reg};
         CRE_ADDR_IDENT: hrdata_next = ident_code;
         default: hrdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= hrdata_next;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule

// ### verification/cre_reset_entry_checker.sv
// Purpose: Assertions on reset entry, status and vectoring
// Assumes: One clock, synchronous active high reset
// Notes: Bound into every reset entry instance
`timescale 1ns/1ps
module cre_reset_entry_checker
   import cre_pkg::*;
#(
   parameter logic has_xlate = 1'b1
)(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic exc_req_in,
   input wire logic burst_ok_in,
   input wire logic dup_match_in,
   input wire cre_fetch_s fetch_out,
   input wire cre_status_s status_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////
   sequence s_rel;
      $fell(sys_rst_in);
   endsequence
   sequence s_exc(bv);
      exc_req_in && status_out.boot_vec == bv;
   endsequence
   property p_first;
      s_rel |=> fetch_out.valid && fetch_out.addr == CRE_RESET_VADDR;
   endproperty
   property p_stat;
      s_rel |-> !status_out.user_mode && !status_out.int_enable && status_out.boot_vec;
   endproperty
   property p_ts;
      s_rel |-> status_out.shutdown == !has_xlate;
   endproperty
   property p_seg;
      fetch_out.valid && fetch_out.addr[31:29] == CRE_SEG_TOP |-> fetch_out.uncached;
   endproperty
   property p_burst;
      fetch_out.valid && !burst_ok_in |-> fetch_out.uncached;
   endproperty
   property p_bvec;
      s_exc(1'b1) |=> fetch_out.addr == CRE_BOOT_EXC_VADDR;
   endproperty
   property p_nvec;
      s_exc(1'b0) |=> fetch_out.addr == CRE_NORM_EXC_VADDR;
   endproperty
   property p_dup;
      dup_match_in |=> status_out.shutdown;
   endproperty
   property p_stick;
      status_out.shutdown |=> status_out.shutdown;
   endproperty
   a_first: assert property (p_first) else $error("Bad first fetch");
   a_stat: assert property (p_stat) else $error("Bad status after reset");
   a_ts: assert property (p_ts) else $error("Bad shutdown flag");
   a_seg: assert property (p_seg) else $error("Segment fetch cached");
   a_burst: assert property (p_burst) else $error("Burstless fetch cached");
   a_bvec: assert property (p_bvec) else $error("Bad boot vector");
   a_nvec: assert property (p_nvec) else $error("Bad normal vector");
   a_dup: assert property (p_dup) else $error("No shutdown");
   a_stick: assert property (p_stick) else $error("Shutdown left");
endmodule
bind cre_reset_entry cre_reset_entry_checker #(.has_xlate(has_xlate)) u_chk (.*);

// ### verification/cre_boot_rom.sv
// Purpose: Boot ROM seen from the fetch port
// Assumes: Narrow ROM, no bursts
// Notes: answer_in low stalls the fetch stream
`timescale 1ns/1ps
module cre_boot_rom
   import cre_pkg::*;
#(
   parameter logic [31:0] main_addr = 32'hbfc0_0400
)(
   input wire logic answer_in,
   input wire cre_fetch_s fetch_in,
   output logic fetch_adv_out,
   output logic [31:0] next_pc_out,
   output logic burst_ok_out
);
   ////////////////////////////////////////
   // Cannot burst, so code must run uncached
   assign burst_ok_out = 1'b0;
   assign fetch_adv_out = answer_in && fetch_in.valid;
   // Branch first, clear of the vectors, before any status write
   assign next_pc_out = (fetch_in.addr == CRE_RESET_VADDR) ? main_addr : fetch_in.addr + 32'h4;
endmodule

// ### verification/cpu_reset_entry_test.sv
// Purpose: Directed test of reset entry over AHB-Lite
// Assumes: Zero wait slave, ROM model on the fetch port
// Notes: Ends through results
`timescale 1ns/1ps
module cpu_reset_entry_test;
   import cre_pkg::*;
   logic core_clk_in, sys_rst_in, exc_req_in, dup_match_in, hsel, hwrite, answer;
   logic fetch_adv_in, burst_ok_in, hreadyout, hresp, irq_out;
   logic [31:0] pc_in, next_pc_in, haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   cre_fetch_s fetch_out;
   cre_status_s status_out;
   int fails, comparisons;
   cre_reset_entry dut (.*, .hready(hreadyout));
   cre_boot_rom rom (.answer_in(answer), .fetch_in(fetch_out), .fetch_adv_out(fetch_adv_in),
      .next_pc_out(next_pc_in), .burst_ok_out(burst_ok_in));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("Mismatches %0d in %0d comparisons", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         results();
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
      rd = hrdata;
   endtask
   task automatic exc(input logic [31:0] vec);
      exc_req_in <= 1'b1;
      @(posedge core_clk_in);
      exc_req_in <= 1'b0;
      @(posedge core_clk_in);
      chk(fetch_out.addr, vec);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial begin
      fails = 0;
      comparisons = 0;
      {sys_rst_in, exc_req_in, dup_match_in, hsel, hwrite, answer} = 6'h20;
      {pc_in, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      tick(3);
      sys_rst_in <= 1'b0;
      tick(2);
      chk(fetch_out.addr, CRE_RESET_VADDR);
      chk(fetch_out.uncached, 1'b1);
      chk(fetch_out.valid, 1'b1);
      chk(hresp, 1'b0);
      chk(hreadyout, 1'b1);
      answer <= 1'b1;
      tick(3);
      answer <= 1'b0;
      tick(1);
      chk(fetch_out.addr, 32'hbfc0_0408);
      bus(0, CRE_ADDR_STATUS, 0);
      chk(rd & 32'h0060_0003, 32'h0040_0000);
      bus(0, CRE_ADDR_IDENT, 0);
      chk(rd, CRE_IDENT_DEFAULT);
      bus(0, 8'h20, 0);
      chk(rd, 0);
      exc(CRE_BOOT_EXC_VADDR);
      bus(0, CRE_ADDR_IRQ_STAT, 0);
      chk(rd & 3, 2);
      bus(1, CRE_ADDR_IRQ_MASK, 3);
      tick(2);
      chk(irq_out, 1'b1);
      bus(1, CRE_ADDR_IRQ_STAT, 2);
      tick(2);
      chk(irq_out, 1'b0);
      bus(1, CRE_ADDR_STATUS, 0);
      bus(0, CRE_ADDR_STATUS, 0);
      chk(rd & 32'h0041_0000, 0);
      exc(CRE_NORM_EXC_VADDR);
      // Clear the exception event so only shutdown can raise the line
      bus(1, CRE_ADDR_IRQ_STAT, 3);
      tick(2);
      chk(irq_out, 1'b0);
      // Deliberate duplicate match, as if firmware skipped buffer setup
      dup_match_in <= 1'b1;
      tick(1);
      dup_match_in <= 1'b0;
      tick(2);
      chk(status_out.shutdown, 1'b1);
      chk(irq_out, 1'b1);
      bus(0, CRE_ADDR_IRQ_STAT, 0);
      chk(rd & 3, 1);
      bus(1, CRE_ADDR_STATUS, 0);
      bus(0, CRE_ADDR_STATUS, 0);
      chk(rd & 32'h0020_0000, 32'h0020_0000);
      pc_in <= 32'h8000_1234;
      tick(1);
      sys_rst_in <= 1'b1;
      tick(3);
      sys_rst_in <= 1'b0;
      tick(2);
      bus(0, CRE_ADDR_RETPC, 0);
      chk(rd, 32'h8000_1234);
      bus(0, CRE_ADDR_STATUS, 0);
      chk(rd & 32'h0060_0003, 32'h0040_0000);
      results();
   end
endmodule
